// ==== src/ebwh_map.vh ====
`ifndef EBWH_MAP_VH
`define EBWH_MAP_VH
// axi4-lite byte offsets
`define EBWH_CFG_OFF 8'h00
`define EBWH_CMD_OFF 8'h04
`define EBWH_STAT_OFF 8'h08
`define EBWH_RDATA_OFF 8'h0C
`define EBWH_WDATA_OFF 8'h10
// configuration field positions
`define EBWH_CFG_WAIT_LSB 0
`define EBWH_CFG_WAIT_MSB 3
`define EBWH_CFG_RWDLY 4
`define EBWH_CFG_ALEXT 5
`define EBWH_CFG_MUX 6
`define EBWH_CFG_TRI 7
`define EBWH_CFG_HOLDEN 8
`define EBWH_CFG_RESET 9'h000
// command bits
`define EBWH_CMD_GO 0
`define EBWH_CMD_WRITE 1
`define EBWH_CMD_REGAIN 2
// axi responses
`define EBWH_RESP_OKAY 2'b00
`define EBWH_RESP_SLVERR 2'b10
`endif

// ==== src/ebwh_sync.v ====
`timescale 1ns/1ps
// two-flop synchroniser for a group of pin inputs
module ebwh_sync #(
    parameter W = 2,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    clock,
    rst,
    d,
    q
);
    input wire clock;
    input wire rst;
    input wire [W-1:0] d;
    output reg [W-1:0] q;
    reg [W-1:0] meta_q; // first stage, read only by q

    // plain two-stage chain; inactive-high level after reset
    always @(posedge clock)
    begin
        if (rst)
        begin
            meta_q <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ebwh_sync

// ==== src/ebwh_ctrl.v ====
// Overview of operation
// - latch read data at strobe end edge
// - delay settings apply to next cycle
// - full programmed wait count before ready check
// - read/write delay postpones strobe assertion
// - ready high adds wait, low ends
// - multiplexed bus appends mux, optional tristate
// - gap two cycles mux+tristate, else fewer
// - hold sampled, grant/regain launched on clock edges
// - running cycle finishes before grant
// - chip selects released, pulled up, on grant
// - regain request sent while granted; bus taken back only when hold withdrawn
`timescale 1ns/1ps
`include "ebwh_map.vh"
module ebwh_ctrl #(
    parameter WAIT_W = 4
) (
    clock,
    rst,
    awvalid,
    awready,
    awaddr,
    wvalid,
    wready,
    wdata,
    wstrb,
    bvalid,
    bready,
    bresp,
    arvalid,
    arready,
    araddr,
    rvalid,
    rready,
    rdata,
    rresp,
    bus_clock_output,
    ready_n,
    hold_n,
    data_in,
    data_out,
    data_oe_n,
    ale,
    rd_n,
    wr_n,
    cs_n_out,
    cs_n_oe_n,
    bus_grant_ack_n,
    bus_regain_request_n
);
    input wire clock;
    input wire rst;
    input wire awvalid;
    output wire awready;
    input wire [7:0] awaddr;
    input wire wvalid;
    output wire wready;
    input wire [31:0] wdata;
    input wire [3:0] wstrb;
    output reg bvalid;
    input wire bready;
    output reg [1:0] bresp;
    input wire arvalid;
    output wire arready;
    input wire [7:0] araddr;
    output reg rvalid;
    input wire rready;
    output reg [31:0] rdata;
    output reg [1:0] rresp;
    output wire bus_clock_output; // cpu clock driven out
    input wire ready_n; // external ready, active low, asynchronous
    input wire hold_n; // external bus request, active low
    input wire [15:0] data_in;
    output reg [15:0] data_out;
    output reg data_oe_n; // low while data pins are driven
    output reg ale;
    output reg rd_n;
    output reg wr_n;
    output wire cs_n_out;
    output reg cs_n_oe_n; // high lets the pull-up win
    output reg bus_grant_ack_n;
    output reg bus_regain_request_n;

    localparam [7:0] S_IDLE = 8'h01; // waiting for work
    localparam [7:0] S_ADDR = 8'h02; // address phase, ale high
    localparam [7:0] S_DLY = 8'h04; // read/write delay phase
    localparam [7:0] S_CMD = 8'h08; // strobe low, wait states
    localparam [7:0] S_RDY = 8'h10; // ready sampling
    localparam [7:0] S_MUX = 8'h20; // multiplex wait state
    localparam [7:0] S_TRI = 8'h40; // tristate wait state
    localparam [7:0] S_HELD = 8'h80; // bus given away

    reg [7:0] state_q;
    reg [8:0] cfg_q; // software configuration
    reg [8:0] act_q; // configuration of the running cycle
    reg go_q; // cycle request pending
    reg wr_q; // pending cycle is a write
    reg done_q; // last cycle completed
    reg [15:0] wdat_q;
    reg [15:0] rdat_q;
    reg [WAIT_W-1:0] cnt_q;
    reg regain_q; // software wants the bus back
    wire [1:0] sync_w;
    wire rdy_s_n;
    wire hold_s_n;

    // ready and hold pins pass two flops before any logic reads them
    ebwh_sync #(.W(2), .INIT(2'b11)) u_sync (
        .clock(clock),
        .rst(rst),
        .d({ready_n, hold_n}),
        .q(sync_w)
    );
    assign rdy_s_n = sync_w[1];
    assign hold_s_n = sync_w[0];

    // the bus clock is the cpu clock itself
    assign bus_clock_output = clock;
    assign cs_n_out = 1'b0;

    // bus cycle sequencer
    always @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            act_q <= 9'h000;
            cnt_q <= {WAIT_W{1'b0}};
            rdat_q <= 16'h0000;
            done_q <= 1'b0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
            cs_n_oe_n <= 1'b1;
            bus_grant_ack_n <= 1'b1;
            bus_regain_request_n <= 1'b1;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    cs_n_oe_n <= 1'b1;
                    if (!hold_s_n && cfg_q[`EBWH_CFG_HOLDEN])
                    begin
                        // no cycle is running here, so grant now
                        state_q <= S_HELD;
                        bus_grant_ack_n <= 1'b0;
                    end
                    else if (go_q)
                    begin
                        // delay settings sampled for this new cycle only
                        act_q <= cfg_q;
                        // one extra address clock when ale is extended
                        cnt_q <= {{(WAIT_W-1){1'b0}}, cfg_q[`EBWH_CFG_ALEXT]};
                        ale <= 1'b1;
                        cs_n_oe_n <= 1'b0;
                        done_q <= 1'b0;
                        data_out <= wdat_q;
                        state_q <= S_ADDR;
                    end
                end
                S_ADDR:
                begin
                    // extended ale stays high for one more clock
                    if (cnt_q != {WAIT_W{1'b0}})
                        cnt_q <= cnt_q - 1'b1;
                    else
                    begin
                        ale <= 1'b0;
                        data_oe_n <= ~wr_q;
                        cnt_q <= act_q[`EBWH_CFG_WAIT_MSB:`EBWH_CFG_WAIT_LSB];
                        if (act_q[`EBWH_CFG_RWDLY])
                            state_q <= S_DLY;
                        else
                        begin
                            rd_n <= wr_q;
                            wr_n <= ~wr_q;
                            state_q <= S_CMD;
                        end
                    end
                end
                S_DLY:
                begin
                    // strobe edge postponed by one clock
                    rd_n <= wr_q;
                    wr_n <= ~wr_q;
                    state_q <= S_CMD;
                end
                S_CMD:
                begin
                    // programmed wait states run out before ready counts
                    if (cnt_q != {WAIT_W{1'b0}})
                        cnt_q <= cnt_q - 1'b1;
                    else
                        state_q <= S_RDY;
                end
                S_RDY:
                begin
                    // ready high: another wait state; low: finish
                    if (!rdy_s_n)
                    begin
                        // data latched on the edge that ends the strobe
                        if (!wr_q)
                            rdat_q <= data_in;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        data_oe_n <= 1'b1;
                        done_q <= 1'b1;
                        if (act_q[`EBWH_CFG_MUX])
                            state_q <= S_MUX;
                        else
                        begin
                            cs_n_oe_n <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_MUX:
                begin
                    if (act_q[`EBWH_CFG_TRI])
                        state_q <= S_TRI;
                    else
                        state_q <= S_IDLE;
                end
                S_TRI:
                    state_q <= S_IDLE;
                S_HELD:
                begin
                    // chip selects float, pulled up by the board
                    cs_n_oe_n <= 1'b1;
                    bus_regain_request_n <= ~regain_q;
                    // regain only once the other master lets go
                    if (hold_s_n)
                    begin
                        bus_grant_ack_n <= 1'b1;
                        bus_regain_request_n <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // axi4-lite slave: one write and one read at a time
    wire wr_take = awvalid && wvalid && !bvalid;
    assign awready = wr_take;
    assign wready = wr_take;
    assign arready = !rvalid;
    wire busy = (state_q != S_IDLE) && (state_q != S_HELD);

    // register writes; a go issued while busy or already pending is dropped
    always @(posedge clock)
    begin
        if (rst)
        begin
            cfg_q <= `EBWH_CFG_RESET;
            go_q <= 1'b0;
            wr_q <= 1'b0;
            wdat_q <= 16'h0000;
            regain_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `EBWH_RESP_OKAY;
        end
        else
        begin
            // launch consumes the request as the cycle starts
            if (state_q == S_IDLE && go_q && !(!hold_s_n &&
                cfg_q[`EBWH_CFG_HOLDEN]))
                go_q <= 1'b0;
            if (state_q == S_HELD && hold_s_n)
                regain_q <= 1'b0;
            if (bvalid && bready)
                bvalid <= 1'b0;
            if (wr_take)
            begin
                bvalid <= 1'b1;
                bresp <= `EBWH_RESP_OKAY;
                case (awaddr)
                    `EBWH_CFG_OFF:
                        if (wstrb[0] && wstrb[1])
                            cfg_q <= wdata[8:0];
                    `EBWH_CMD_OFF:
                    begin
                        if (wdata[`EBWH_CMD_GO] && !go_q && !busy)
                        begin
                            go_q <= 1'b1;
                            wr_q <= wdata[`EBWH_CMD_WRITE];
                        end
                        if (wdata[`EBWH_CMD_REGAIN])
                            regain_q <= 1'b1;
                    end
                    `EBWH_WDATA_OFF:
                        wdat_q <= wdata[15:0];
                    default:
                        bresp <= `EBWH_RESP_SLVERR;
                endcase
            end
        end
    end

    // register reads, answered one cycle after the address is taken
    always @(posedge clock)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `EBWH_RESP_OKAY;
        end
        else if (arvalid && !rvalid)
        begin
            rvalid <= 1'b1;
            rresp <= `EBWH_RESP_OKAY;
            case (araddr)
                `EBWH_CFG_OFF:
                    rdata <= {23'h000000, cfg_q};
                `EBWH_STAT_OFF:
                    rdata <= {20'h00000, ~bus_grant_ack_n, done_q,
                        busy | go_q, ~hold_s_n, state_q};
                `EBWH_RDATA_OFF:
                    rdata <= {16'h0000, rdat_q};
                `EBWH_WDATA_OFF:
                    rdata <= {16'h0000, wdat_q};
                `EBWH_CMD_OFF:
                    rdata <= {29'h00000000, regain_q, wr_q, go_q};
                default:
                begin
                    rdata <= 32'h0000_0000;
                    rresp <= `EBWH_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end
endmodule // ebwh_ctrl

// ==== testbench/ebwh_ctrl_chk.sv ====
`timescale 1ns/1ps
// watches strobe, ready and arbitration pins of the controller
module ebwh_ctrl_chk (
    input wire clock,
    input wire rst,
    input wire ready_n,
    input wire hold_n,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire cs_n_oe_n,
    input wire bus_grant_ack_n,
    input wire bus_regain_request_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire strb_n = rd_n & wr_n; // high while no strobe is active
    // three edges of pin level cover the two-flop sync delay
    sequence s_wait_hi;
        (!strb_n && ready_n) [*3];
    endsequence
    sequence s_wait_lo;
        (!strb_n && !ready_n) [*3];
    endsequence
    a_rst_idle: assert property (
        disable iff (1'b0) rst |=> strb_n && bus_grant_ack_n
        && bus_regain_request_n) else $error("bus not idle after reset");
    a_one_strobe: assert property (
        rd_n || wr_n) else $error("read and write strobes together");
    a_ale_lead: assert property (
        $fell(strb_n) |-> !ale && ($past(ale) || $past(ale, 2)))
        else $error("strobe not placed after address phase");
    a_ready_wait: assert property (
        s_wait_hi |=> !strb_n) else $error("strobe ended without ready");
    a_ready_end: assert property (
        s_wait_lo |-> ##[0:20] strb_n) else $error("ready did not end cycle");
    a_grant_idle: assert property (
        $fell(bus_grant_ack_n) |-> strb_n && $past(strb_n) && !ale)
        else $error("grant during a running cycle");
    a_grant_req: assert property (
        $fell(bus_grant_ack_n) |-> !$past(hold_n, 3))
        else $error("grant without bus request");
    a_cs_float: assert property (
        !bus_grant_ack_n && $past(!bus_grant_ack_n) |-> cs_n_oe_n)
        else $error("chip select driven while granted");
    a_regain_hold: assert property (
        $rose(bus_grant_ack_n) |-> $past(hold_n, 3))
        else $error("bus taken back while request held");
    a_regain_granted: assert property (
        !bus_regain_request_n |-> !bus_grant_ack_n)
        else $error("regain request without grant");
endmodule // ebwh_ctrl_chk

bind ebwh_ctrl ebwh_ctrl_chk chk_u (.clock, .rst, .ready_n, .hold_n,
    .ale, .rd_n, .wr_n, .cs_n_oe_n, .bus_grant_ack_n,
    .bus_regain_request_n);

// ==== testbench/ebwh_mem_model.sv ====
`timescale 1ns/1ps
// far-side memory: answers ready after a chosen number of cycles
module ebwh_mem_model (
    input wire clock,
    input wire rd_n,
    input wire wr_n,
    input wire [15:0] data_out,
    input wire [3:0] dly,
    input wire [15:0] rval,
    output logic ready_n,
    output logic [15:0] data_in,
    output logic [15:0] wr_seen
);
    logic [3:0] cnt_q; // cycles since the strobe fell
    initial
    begin
        ready_n = 1'b1;
        data_in = 16'h0000;
        cnt_q = 4'h0;
    end
    // ready stays low until the strobe rises so a slow sync sees it
    always @(posedge clock)
    begin
        if (rd_n && wr_n)
        begin
            cnt_q <= 4'h0;
            ready_n <= 1'b1; // withdrawn on trailing edge
        end
        else if (cnt_q == dly)
            ready_n <= 1'b0; // held low to strobe end
        else
            cnt_q <= cnt_q + 4'h1;
        if (!wr_n)
            wr_seen <= data_out;
        // data valid only with ready; otherwise the bus toggles,
        // so an early or late capture never passes
        data_in <= (!rd_n && !ready_n) ? rval : ~data_in;
    end
endmodule // ebwh_mem_model

// ==== testbench/ebwh_ctrl_bench.sv ====
`timescale 1ns/1ps
`include "ebwh_map.vh"
module ebwh_ctrl_bench;
    logic clock, rst, awvalid, wvalid, bready, arvalid, rready, hold_n;
    logic ready_n, ale, rd_n, wr_n, cs_n_out, cs_n_oe_n, data_oe_n;
    logic awready, wready, bvalid, arready, rvalid, bus_clock_output;
    logic bus_grant_ack_n, bus_regain_request_n, wrt;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv, cfg, cur, wd;
    logic [3:0] wstrb, dly;
    logic [1:0] bresp, rresp, br;
    logic [15:0] data_in, data_out, rval, wr_seen;
    int err_count, n_tests, cyc, a_len, s_len, gap, i, tail, oe_bad;
    ebwh_ctrl dut_u (.clock, .rst, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .bus_clock_output, .ready_n, .hold_n, .data_in, .data_out,
        .data_oe_n, .ale, .rd_n, .wr_n, .cs_n_out, .cs_n_oe_n,
        .bus_grant_ack_n, .bus_regain_request_n);
    ebwh_mem_model mem_u (.clock, .rd_n, .wr_n, .data_out, .dly, .rval,
        .ready_n, .data_in, .wr_seen);
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ale width, ale-to-strobe gap, strobe width; also the timeout
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (ale)
            a_len <= a_len + 1;
        if (!ale && rd_n && wr_n && a_len > 0 && s_len == 0)
            gap <= gap + 1;
        if (!(rd_n && wr_n))
            s_len <= s_len + 1;
        // select still driven after the strobe: mux and tristate waits
        if (rd_n && wr_n && !cs_n_oe_n && s_len > 0)
            tail <= tail + 1;
        // data pins drive during writes only
        if (!(rd_n && wr_n) && data_oe_n !== wr_n)
            oe_bad <= oe_bad + 1;
        if (cyc == 20000)
        begin
            err_count++;
            summarize;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // aw and w offered together, held until taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clock); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clock); while (!bvalid);
        br = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask
    function automatic int ale_len(input logic [31:0] c);
        return 1 + c[`EBWH_CFG_ALEXT]; // extended address phase
    endfunction
    function automatic int tail_len(input logic [31:0] c);
        // mux wait, optional tristate wait, then idle frees the select
        return c[`EBWH_CFG_MUX] ? 2 + c[`EBWH_CFG_TRI] : 0;
    endfunction
    task automatic summarize;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {rst, hold_n, wstrb} = 6'h3F;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, dly, rval} = 68'h0;
        {err_count, n_tests, cyc, a_len, s_len, gap, tail, oe_bad} = 0;
        void'($urandom(26));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("idle", {rd_n, wr_n, bus_grant_ack_n}, 3'h7);
        #1 chk("bus clock", bus_clock_output, clock);
        cfg = $urandom & 32'hFF;
        axw(`EBWH_CFG_OFF, cfg);
        repeat (12)
        begin
            cur = cfg;
            wrt = $urandom % 2;
            wd = $urandom;
            dly <= $urandom % 4;
            rval <= $urandom;
            axw(`EBWH_WDATA_OFF, wd);
            {a_len, s_len, gap, tail} = 0;
            axw(`EBWH_CMD_OFF, {30'h0, wrt, 1'b1});
            // new settings land while the cycle still runs
            cfg = $urandom & 32'hFF;
            axw(`EBWH_CFG_OFF, cfg);
            for (i = 0; i < 20; i++)
            begin
                axr(`EBWH_STAT_OFF, rv);
                if (rv[9] === 1'b0 && s_len > 0)
                    break;
            end
            chk("ale width", a_len, ale_len(cur));
            chk("strobe gap", gap, cur[`EBWH_CFG_RWDLY]);
            chk("strobe width", s_len > cur[3:0], 1);
            chk("bus gap", tail, tail_len(cur));
            if (wrt)
                chk("write data", wr_seen, wd[15:0]);
            else
            begin
                axr(`EBWH_RDATA_OFF, rv);
                chk("read data", rv, {16'h0, rval});
            end
        end
        axw(`EBWH_CFG_OFF, 32'h10F);
        dly <= 4'h3;
        {a_len, s_len, gap} = 0;
        axw(`EBWH_CMD_OFF, 32'h1);
        hold_n <= 1'b0; // request arrives mid-cycle
        for (i = 0; i < 80 && bus_grant_ack_n !== 1'b0; i++)
            @(posedge clock);
        chk("grant", bus_grant_ack_n, 0);
        chk("cycle done", s_len > 15, 1);
        chk("cs released", cs_n_oe_n, 1);
        axw(`EBWH_CMD_OFF, 32'h4);
        for (i = 0; i < 80 && bus_regain_request_n !== 1'b0; i++)
            @(posedge clock);
        chk("regain", bus_regain_request_n, 0);
        chk("still granted", bus_grant_ack_n, 0);
        hold_n <= 1'b1;
        for (i = 0; i < 80 && bus_grant_ack_n !== 1'b1; i++)
            @(posedge clock);
        chk("released", bus_grant_ack_n, 1);
        axw(8'hFC, 32'h0);
        chk("bad write", br, `EBWH_RESP_SLVERR);
        axr(8'hFC, rv);
        chk("bad read", rv, 32'h0);
        chk("bad resp", rresp, `EBWH_RESP_SLVERR);
        // second grant, then a reset while the bus is given away
        hold_n <= 1'b0;
        axw(`EBWH_CFG_OFF, 32'h100);
        for (i = 0; i < 80 && bus_grant_ack_n !== 1'b0; i++)
            @(posedge clock);
        chk("grant again", bus_grant_ack_n, 0);
        chk("no regain", bus_regain_request_n, 1);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("reset grant", {bus_grant_ack_n, bus_regain_request_n}, 2'h3);
        axr(`EBWH_CFG_OFF, rv);
        chk("reset cfg", rv, 32'h0);
        chk("still owned", bus_grant_ack_n, 1);
        hold_n <= 1'b1;
        chk("data drive", oe_bad, 0);
        chk("cs level", cs_n_out, 0);
        summarize;
    end
endmodule // ebwh_ctrl_bench
